// [core/ddr_sram_params.svh]
// Timing counts and field widths for the separate-I/O DDR SRAM port
`ifndef DDR_SRAM_PARAMS_SVH
`define DDR_SRAM_PARAMS_SVH
`define ZQ_SETTLE_CYCLES 163840
`define DLL_LOCK_CYCLES 65536
`define CLK_STOP_NS 30
`define SYS_CLK_NS 20
`define CLK_STOP_CYCLES ((`CLK_STOP_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define LANE_BITS 9
`define WORD_BITS 18
`define CHECK_BITS 5
`define LINK_DIV 4
`endif

// [core/ddr_sram_pkg.sv]
// Types used by the controller end of the DDR SRAM link
package ddr_sram_pkg;
  typedef enum logic [3:0] {
    ST_POWER = 4'b0001,
    ST_IMPED = 4'b0010,
    ST_LOCK = 4'b0100,
    ST_READY = 4'b1000
  } init_state_e;
endpackage

// [core/ddr_sram_if.sv]
// Pin bundle between memory controller and SRAM device
`timescale 1ns/1ps
interface ddr_sram_if #(parameter int AW = 8, parameter int LANES = 2);
  logic in_clk;
  logic in_clk_n;
  logic out_clk;
  logic out_clk_n;
  logic read_sel_n;
  logic write_sel_n;
  logic [AW-1:0] sync_address_in;
  logic [LANES*9-1:0] write_data_in;
  logic [LANES-1:0] lane_write_mask_n;
  logic dll_off_n;
  logic [LANES*9-1:0] read_data_out;
  logic read_data_oe;
  logic echo_clock_out;
  logic echo_clock_out_n;
  modport ctrl (output in_clk, in_clk_n, out_clk, out_clk_n, read_sel_n, write_sel_n, sync_address_in,
    write_data_in, lane_write_mask_n, dll_off_n, input read_data_out, read_data_oe, echo_clock_out,
    echo_clock_out_n);
  modport dev (input in_clk, in_clk_n, out_clk, out_clk_n, read_sel_n, write_sel_n, sync_address_in,
    write_data_in, lane_write_mask_n, dll_off_n, output read_data_out, read_data_oe, echo_clock_out,
    echo_clock_out_n);
endinterface

// [core/ddr_sram_dev.sv]
// Device end: DDR burst-of-two SRAM with per-lane Hamming protection
`timescale 1ns/1ps
`include "ddr_sram_params.svh"
module ddr_sram_dev #(
  parameter int AW = 8,
  parameter int LANES = 2,
  parameter int LOCK_CYCLES = `DLL_LOCK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  ddr_sram_if.dev pins,
  output logic dll_locked,
  output logic ecc_enabled,
  output logic ecc_corrected
);
  localparam int DW = LANES * 9;
  localparam int CW = `WORD_BITS + `CHECK_BITS;
  localparam int SW = 6;

  // Hamming(23,18) encode: data into non-power-of-two positions
  function automatic logic [22:0] ham_enc(input logic [17:0] d);
    logic [22:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p <= 23; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 5; b++) begin
      for (int p = 1; p <= 23; p++) begin
        if (((p >> b) & 1) == 1 && p != (1 << b)) begin
          cw[(1<<b)-1] = cw[(1<<b)-1] ^ cw[p-1];
        end
      end
    end
    return cw;
  endfunction

  // Syndrome of a stored word; zero means clean
  function automatic logic [4:0] ham_syn(input logic [22:0] cw);
    logic [4:0] s;
    s = '0;
    for (int p = 1; p <= 23; p++) begin
      if (cw[p-1]) begin
        s = s ^ 5'(p);
      end
    end
    return s;
  endfunction

  // Pull data bits back out of a codeword
  function automatic logic [17:0] ham_dec(input logic [22:0] cw);
    logic [17:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p <= 23; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = cw[p-1];
        k++;
      end
    end
    return d;
  endfunction

  // =========================================
  // Pin synchronisers: three flops, a rise counts while 2nd is high and 3rd still low
  logic [2:0] k_sync_reg, kn_sync_reg, c_sync_reg, cn_sync_reg, doff_sync_reg;
  always_ff @(posedge clock) begin
    k_sync_reg <= {k_sync_reg[1:0], pins.in_clk};
    kn_sync_reg <= {kn_sync_reg[1:0], pins.in_clk_n};
    c_sync_reg <= {c_sync_reg[1:0], pins.out_clk};
    cn_sync_reg <= {cn_sync_reg[1:0], pins.out_clk_n};
    doff_sync_reg <= {doff_sync_reg[1:0], pins.dll_off_n};
  end
  // Rising edges seen when stage 2 is high and stage 3 low; data pins sampled alongside
  wire k_rise = k_sync_reg[1] & ~k_sync_reg[2];
  wire kn_rise = kn_sync_reg[1] & ~kn_sync_reg[2];
  wire c_rise = c_sync_reg[1] & ~c_sync_reg[2];
  wire cn_rise = cn_sync_reg[1] & ~cn_sync_reg[2];
  wire c_tied = c_sync_reg[2] & cn_sync_reg[2];
  wire fire_first = c_tied ? kn_rise : cn_rise;
  wire fire_second = c_tied ? k_rise : c_rise;

  // Command and data pins delayed to line up with the clock edge detect
  logic [1:0] rsel_d_reg, wsel_d_reg;
  logic [AW-1:0] addr_d1_reg, addr_d2_reg;
  logic [DW-1:0] wd_d1_reg, wd_d2_reg;
  logic [LANES-1:0] bw_d1_reg, bw_d2_reg;
  always_ff @(posedge clock) begin
    rsel_d_reg <= {rsel_d_reg[0], pins.read_sel_n};
    wsel_d_reg <= {wsel_d_reg[0], pins.write_sel_n};
    addr_d1_reg <= pins.sync_address_in;
    addr_d2_reg <= addr_d1_reg;
    wd_d1_reg <= pins.write_data_in;
    wd_d2_reg <= wd_d1_reg;
    bw_d1_reg <= pins.lane_write_mask_n;
    bw_d2_reg <= bw_d1_reg;
  end

  // =========================================
  // DLL model: held reset by dll off low or a stalled input clock
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_reg;
  logic [7:0] stall_cnt_reg;
  wire clk_stalled = stall_cnt_reg >= 8'(`CLK_STOP_CYCLES + 4);
  always_ff @(posedge clock) begin
    if (rst || k_rise) begin
      stall_cnt_reg <= '0;
    end else if (!clk_stalled) begin
      stall_cnt_reg <= stall_cnt_reg + 8'd1;
    end
    if (rst || !doff_sync_reg[2] || clk_stalled) begin
      lock_cnt_reg <= '0;
      dll_locked <= 1'b0;
    end else if (k_rise && !dll_locked) begin
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
      dll_locked <= (lock_cnt_reg == ($bits(lock_cnt_reg))'(LOCK_CYCLES - 1));
    end
  end

  // =========================================
  // Memory: one 23-bit codeword per lane per address
  logic [CW-1:0] mem [0:(1<<AW)-1][0:LANES-1];
  logic wr_pend_reg, rd_pend_reg, rd_second_reg;
  logic [AW-1:0] rd_addr_reg;
  logic [DW-1:0] beat0_reg, beat1_reg;
  logic [LANES-1:0] bw0_reg;
  logic [DW-1:0] rd_word_hi_reg;

  // Write: command and beat one on K, address and beat two on K bar
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      ecc_enabled <= 1'b1;
    end else begin
      if (k_rise) begin
        wr_pend_reg <= ~wsel_d_reg[1];
        beat0_reg <= wd_d2_reg;
        bw0_reg <= bw_d2_reg;
      end
      if (kn_rise && wr_pend_reg) begin
        wr_pend_reg <= 1'b0;
        for (int l = 0; l < LANES; l++) begin
          logic [17:0] old_d, new_d;
          old_d = ham_dec(mem[addr_d2_reg][l]);
          new_d[8:0] = bw0_reg[l] ? old_d[8:0] : beat0_reg[l*9 +: 9];
          new_d[17:9] = bw_d2_reg[l] ? old_d[17:9] : wd_d2_reg[l*9 +: 9];
          if (bw0_reg[l] != bw_d2_reg[l]) begin
            ecc_enabled <= 1'b0;
          end
          if (!(bw0_reg[l] & bw_d2_reg[l])) begin
            mem[addr_d2_reg][l] <= ham_enc(new_d);
          end
        end
      end
    end
  end

  // Read: capture on K, fetch and correct, drive two beats on output clocks, or on K bar then K while both output clocks are tied high
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_pend_reg <= 1'b0;
      rd_second_reg <= 1'b0;
      pins.read_data_oe <= 1'b0;
      pins.read_data_out <= '0;
      ecc_corrected <= 1'b0;
    end else begin
      ecc_corrected <= 1'b0;
      if (k_rise && !rd_pend_reg && !rd_second_reg) begin
        rd_pend_reg <= ~rsel_d_reg[1];
        rd_addr_reg <= addr_d2_reg;
      end
      if (fire_first && rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rd_second_reg <= 1'b1;
        pins.read_data_oe <= 1'b1;
        for (int l = 0; l < LANES; l++) begin
          logic [22:0] cw;
          logic [4:0] s;
          logic [17:0] d;
          cw = mem[rd_addr_reg][l];
          s = ham_syn(cw);
          if (ecc_enabled && s != 5'd0 && s <= 5'd23) begin
            cw[s-1] = ~cw[s-1];
            ecc_corrected <= 1'b1;
          end
          d = ham_dec(cw);
          pins.read_data_out[l*9 +: 9] <= d[8:0];
          rd_word_hi_reg[l*9 +: 9] <= d[17:9];
        end
      end else if (fire_second && rd_second_reg) begin
        pins.read_data_out <= rd_word_hi_reg;
        rd_second_reg <= 1'b0;
      end else if (fire_first && !rd_pend_reg && !rd_second_reg) begin
        pins.read_data_oe <= 1'b0;
      end
    end
  end

  // Echo clocks follow whichever pair fires the outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      pins.echo_clock_out <= 1'b0;
      pins.echo_clock_out_n <= 1'b1;
    end else begin
      pins.echo_clock_out <= c_tied ? k_sync_reg[2] : c_sync_reg[2];
      pins.echo_clock_out_n <= c_tied ? kn_sync_reg[2] : cn_sync_reg[2];
    end
  end
endmodule

// [core/ddr_sram_ctrl.sv]
// Controller end: drives clocks, power-up waits and burst commands
`timescale 1ns/1ps
`include "ddr_sram_params.svh"
module ddr_sram_ctrl #(
  parameter int AW = 8,
  parameter int LANES = 2,
  parameter int IMPED_CYCLES = `ZQ_SETTLE_CYCLES,
  parameter int LOCK_CYCLES = `DLL_LOCK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  ddr_sram_if.ctrl pins,
  input wire logic relock_req,
  input wire logic rd_req,
  input wire logic [AW-1:0] rd_addr,
  input wire logic wr_req,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [2*LANES*9-1:0] wr_data,
  input wire logic [2*LANES-1:0] wr_mask_n,
  output logic ready,
  output logic busy,
  output logic [2*LANES*9-1:0] rd_data,
  output logic rd_valid
);
  localparam int DW = LANES * 9;
  logic [1:0] div_reg;
  logic [$clog2(IMPED_CYCLES+1)-1:0] cnt_reg;
  ddr_sram_pkg::init_state_e st_reg;
  logic rd_go_reg, wr_go_reg;
  logic [AW-1:0] wa_reg;
  logic [DW-1:0] d1_reg;
  logic [LANES-1:0] m1_reg;
  logic [2:0] e_sync_reg;
  logic [1:0] q_cnt_reg;
  logic [2:0] ek_sync_reg;
  logic [DW-1:0] q_d1_reg;
  logic [DW-1:0] q_d2_reg;
  logic [1:0] oe_d_reg;

  // =========================================
  // Link clock divider: K rises at phase 0, K bar at phase 2
  wire phase0 = div_reg == 2'd3;
  always_ff @(posedge clock) begin
    if (rst) begin
      div_reg <= '0;
      pins.in_clk <= 1'b0;
      pins.in_clk_n <= 1'b1;
    end else begin
      div_reg <= div_reg + 2'd1;
      pins.in_clk <= (div_reg == 2'd3) || (div_reg == 2'd0);
      pins.in_clk_n <= (div_reg == 2'd1) || (div_reg == 2'd2);
    end
  end

  // Output clocks tied high: device falls back on K pair
  always_ff @(posedge clock) begin
    pins.out_clk <= 1'b1;
    pins.out_clk_n <= 1'b1;
  end

  // Power-up: dll off low through impedance wait, then lock wait
  wire k_edge = phase0;
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= ddr_sram_pkg::ST_IMPED;
      cnt_reg <= '0;
      pins.dll_off_n <= 1'b0;
      ready <= 1'b0;
    end else begin
      case (st_reg)
        ddr_sram_pkg::ST_IMPED: begin
          if (k_edge) cnt_reg <= cnt_reg + 1'b1;
          if (k_edge && cnt_reg == ($bits(cnt_reg))'(IMPED_CYCLES - 1)) begin
            st_reg <= ddr_sram_pkg::ST_LOCK;
            cnt_reg <= '0;
            pins.dll_off_n <= 1'b1;
          end
        end
        ddr_sram_pkg::ST_LOCK: begin
          if (k_edge) cnt_reg <= cnt_reg + 1'b1;
          if (k_edge && cnt_reg == ($bits(cnt_reg))'(LOCK_CYCLES - 1)) begin
            st_reg <= ddr_sram_pkg::ST_READY;
            ready <= 1'b1;
          end
        end
        ddr_sram_pkg::ST_READY: begin
          if (relock_req) begin
            st_reg <= ddr_sram_pkg::ST_POWER;
            pins.dll_off_n <= 1'b0;
            ready <= 1'b0;
          end
        end
        ddr_sram_pkg::ST_POWER: begin
          st_reg <= ddr_sram_pkg::ST_LOCK;
          cnt_reg <= '0;
          pins.dll_off_n <= 1'b1;
        end
        default: st_reg <= ddr_sram_pkg::ST_IMPED;
      endcase
    end
  end

  // Commands: select, read address and beat one before K, write address and beat two before K bar
  always_ff @(posedge clock) begin
    if (rst) begin
      pins.read_sel_n <= 1'b1;
      pins.write_sel_n <= 1'b1;
      pins.sync_address_in <= '0;
      pins.write_data_in <= '0;
      pins.lane_write_mask_n <= '1;
      rd_go_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      busy <= 1'b0;
    end else if (div_reg == 2'd1 && !busy) begin
      rd_go_reg <= ready & rd_req;
      wr_go_reg <= ready & wr_req;
      busy <= ready & (rd_req | wr_req);
      wa_reg <= wr_addr;
      d1_reg <= wr_data[DW-1:0]; // Lower half is beat two
      m1_reg <= wr_mask_n[LANES-1:0];
    end else if (div_reg == 2'd2) begin
      pins.read_sel_n <= ~rd_go_reg;
      pins.write_sel_n <= ~wr_go_reg;
      pins.sync_address_in <= rd_addr;
      pins.write_data_in <= wr_data[2*DW-1:DW];
      pins.lane_write_mask_n <= wr_mask_n[2*LANES-1:LANES];
    end else if (div_reg == 2'd0) begin
      pins.read_sel_n <= 1'b1;
      pins.write_sel_n <= 1'b1;
      pins.sync_address_in <= wa_reg;
      pins.write_data_in <= d1_reg;
      pins.lane_write_mask_n <= m1_reg;
      rd_go_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      if (wr_go_reg && !rd_go_reg) begin
        busy <= 1'b0; // A lone write is done once beat two is out
      end
    end else if (rd_valid) begin
      busy <= 1'b0; // Read busy until both beats are back
    end
  end

  // Read return: beat one on inverted echo rise, beat two on true echo rise
  // Data and enable go through two flops so they line up with the echo synchronisers
  wire echo_n_rise = e_sync_reg[1] & ~e_sync_reg[2];
  wire echo_rise = ek_sync_reg[1] & ~ek_sync_reg[2];
  always_ff @(posedge clock) begin
    e_sync_reg <= {e_sync_reg[1:0], pins.echo_clock_out_n};
    ek_sync_reg <= {ek_sync_reg[1:0], pins.echo_clock_out};
    q_d1_reg <= pins.read_data_out;
    q_d2_reg <= q_d1_reg;
    oe_d_reg <= {oe_d_reg[0], pins.read_data_oe};
    if (rst) begin
      q_cnt_reg <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (oe_d_reg[1] && (echo_n_rise || echo_rise)) begin
        q_cnt_reg <= q_cnt_reg + 2'd1;
        rd_data <= {rd_data[DW-1:0], q_d2_reg};
        rd_valid <= q_cnt_reg[0];
      end
    end
  end
endmodule

// [sim/ddr_sram_sva.sv]
// Checker of the pin-level rules between the DDR SRAM controller and device
`timescale 1ns/1ps
module ddr_sram_sva #(
  parameter int AW = 8,
  parameter int LANES = 2,
  parameter int IMPED = 16,
  parameter int LOCK = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [AW-1:0] sync_address_in,
  input wire logic [LANES*9-1:0] write_data_in,
  input wire logic [LANES-1:0] lane_write_mask_n,
  input wire logic dll_off_n,
  input wire logic [LANES*9-1:0] read_data_out,
  input wire logic read_data_oe,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n
);
  // ==================================================
  // Helper counters
  // Ages saturate so a long idle stretch never wraps back into range
  logic [7:0] rd_age_reg;
  logic [7:0] idle_reg;
  logic [7:0] k_age_reg;
  logic k_prev_reg;
  logic [19:0] up_reg;
  logic [19:0] hi_reg;
  wire any_sel = !read_sel_n || !write_sel_n;
  wire [7:0] rd_age_next = !read_sel_n ? 8'h00 : rd_age_reg + {7'h00, rd_age_reg != 8'hff};
  wire [7:0] idle_next = any_sel ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hff};
  wire [7:0] k_age_next = (in_clk != k_prev_reg) ? 8'h00 : k_age_reg + {7'h00, k_age_reg != 8'hff};
  wire [19:0] up_next = up_reg + {19'h0_0000, up_reg != 20'hf_ffff};
  wire [19:0] hi_next = !dll_off_n ? 20'h0_0000 : hi_reg + {19'h0_0000, hi_reg != 20'hf_ffff};

  // Counter registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_age_reg <= 8'hff;
      idle_reg <= 8'h00;
      k_age_reg <= 8'h00;
      up_reg <= 20'h0_0000;
      hi_reg <= 20'h0_0000;
    end else begin
      rd_age_reg <= rd_age_next;
      idle_reg <= idle_next;
      k_age_reg <= k_age_next;
      up_reg <= up_next;
      hi_reg <= hi_next;
    end
    k_prev_reg <= in_clk;
  end

  // ==================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_imped_wait: assert property (
    up_reg < IMPED |-> !dll_off_n) else $error("dll enable raised before impedance wait");
  chk_lock_before_use: assert property (
    any_sel |-> hi_reg >= LOCK) else $error("command issued before dll lock time");
  chk_read_cause: assert property (
    $rose(read_data_oe) |-> rd_age_reg <= 8'h10) else $error("read data driven without a read");
  chk_idle_no_drive: assert property (
    idle_reg >= 8'h18 |-> !read_data_oe) else $error("read data driven while deselected");
  chk_burst_two: assert property (
    $rose(read_data_oe) |-> read_data_oe [*4]) else $error("read burst cut short");
  chk_beat_hold: assert property (
    $rose(read_data_oe) |=> $stable(read_data_out)) else $error("first beat not held");
  chk_out_clk_tied: assert property (
    out_clk && out_clk_n) else $error("output clocks not tied high");
  chk_sel_setup: assert property (
    $rose(in_clk) |-> $stable(read_sel_n) && $stable(write_sel_n)) else $error("select moved at clock");
  chk_addr_setup: assert property (
    $rose(in_clk_n) |-> $stable(sync_address_in) && $stable(write_data_in) && $stable(lane_write_mask_n))
    else $error("address or second beat moved at inverted clock");
  chk_echo_step: assert property (
    $changed(echo_clock_out) || $changed(echo_clock_out_n) |-> k_age_reg <= 8'h06)
    else $error("echo clock moved without input clock");
endmodule

// [sim/tb.sv]
// Bench joining controller and device ends over the pin interface
`timescale 1ns/1ps
`define CHECK(nm, ex, ac) \
  begin \
    n_checks++; \
    if ((ac) !== (ex)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", nm, (ex), (ac)); \
    end \
  end
module tb;
  // Short waits keep the run brief; both ends and the checker share LCK, the controller and the checker take IMP
  localparam int IMP = 16;
  localparam int LCK = 32;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic relock_req = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] wr_addr = 8'h00;
  logic [35:0] wr_data = 36'h0_0000_0000;
  logic [3:0] wr_mask_n = 4'hf;
  logic ready, busy, rd_valid, dll_locked, ecc_enabled, ecc_corrected;
  logic [35:0] rd_data;
  logic [35:0] shadow [256];
  logic corr_seen = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  // ==================================================
  // Clock, hang guard and correction monitor
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (ecc_corrected === 1'b1) corr_seen = 1'b1;
    if (cycles >= 20000) begin
      num_errors++;
      $display("Error timeout expected below 20000 seen %0d", cycles);
      conclude();
    end
  end

  // ==================================================
  // Both ends and the checker
  // Default widths: 8-bit address, two lanes
  ddr_sram_if u_ddr_sram_if ();
  ddr_sram_ctrl #(.IMPED_CYCLES(IMP), .LOCK_CYCLES(LCK)) u_ddr_sram_ctrl (
    .clock(clock), .rst(rst), .pins(u_ddr_sram_if.ctrl), .relock_req(relock_req), .rd_req(rd_req),
    .rd_addr(rd_addr), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n),
    .ready(ready), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));
  ddr_sram_dev #(.LOCK_CYCLES(LCK)) u_ddr_sram_dev (.clock(clock), .rst(rst),
    .pins(u_ddr_sram_if.dev), .dll_locked(dll_locked), .ecc_enabled(ecc_enabled), .ecc_corrected(ecc_corrected));
  ddr_sram_sva #(.IMPED(IMP), .LOCK(LCK)) u_ddr_sram_sva (.clock(clock), .rst(rst),
    .in_clk(u_ddr_sram_if.in_clk), .in_clk_n(u_ddr_sram_if.in_clk_n), .out_clk(u_ddr_sram_if.out_clk),
    .out_clk_n(u_ddr_sram_if.out_clk_n), .read_sel_n(u_ddr_sram_if.read_sel_n),
    .write_sel_n(u_ddr_sram_if.write_sel_n), .sync_address_in(u_ddr_sram_if.sync_address_in),
    .write_data_in(u_ddr_sram_if.write_data_in), .lane_write_mask_n(u_ddr_sram_if.lane_write_mask_n),
    .dll_off_n(u_ddr_sram_if.dll_off_n), .read_data_out(u_ddr_sram_if.read_data_out),
    .read_data_oe(u_ddr_sram_if.read_data_oe), .echo_clock_out(u_ddr_sram_if.echo_clock_out),
    .echo_clock_out_n(u_ddr_sram_if.echo_clock_out_n));

  // ==================================================
  // Shared drivers
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || ready !== 1'b1) && n < 400) begin
      step();
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("Error idle wait expected 1 seen 0");
    end
  endtask

  // Holds the request until busy shows it was taken
  task automatic issue(input logic rd, input logic wr, input logic [7:0] ra, input logic [7:0] wa,
    input logic [35:0] d, input logic [3:0] m);
    int n;
    step();
    wait_idle();
    rd_req = rd;
    wr_req = wr;
    rd_addr = ra;
    wr_addr = wa;
    wr_data = d;
    wr_mask_n = m;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    rd_req = 1'b0;
    wr_req = 1'b0;
  endtask

  // Mask bit i guards data bits 9i+8..9i; high keeps the stored lane
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] m);
    logic [35:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) r[9*i +: 9] = nw[9*i +: 9];
    end
    return r;
  endfunction

  task automatic wait_read(input logic [7:0] a);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    `CHECK("rd_data", shadow[a], rd_data)
  endtask

  task automatic do_read(input logic [7:0] a);
    issue(1'b1, 1'b0, a, 8'h00, 36'h0_0000_0000, 4'hf);
    wait_read(a);
  endtask

  task automatic do_write(input logic [7:0] a, input logic [35:0] d, input logic [3:0] m);
    issue(1'b0, 1'b1, 8'h00, a, d, m);
    shadow[a] = merge(shadow[a], d, m);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_power();
    int n;
    n = 0;
    `CHECK("ready_at_reset", 1'b0, ready)
    `CHECK("dll_off_at_reset", 1'b0, u_ddr_sram_if.dll_off_n)
    `CHECK("ecc_at_reset", 1'b1, ecc_enabled)
    while (ready !== 1'b1 && n < 2000) begin
      step();
      n++;
    end
    `CHECK("power_wait", 1'b1, n >= IMP + LCK)
    $display("test power done");
  endtask

  task automatic t_rw();
    do_write(8'h05, 36'h1_2345_6789, 4'h0);
    do_write(8'h06, 36'hf_edcb_a987, 4'h0);
    do_read(8'h05);
    do_read(8'h06);
    `CHECK("dll_locked", 1'b1, dll_locked)
    $display("test write read done");
  endtask

  task automatic t_mask();
    do_write(8'h05, 36'h0_aaaa_5555, 4'b1010);
    do_write(8'h06, 36'h0_0000_0000, 4'hf);
    do_read(8'h05);
    do_read(8'h06);
    `CHECK("ecc_kept", 1'b1, ecc_enabled)
    $display("test mask done");
  endtask

  // Read and write share one command slot; neither may disturb the other
  task automatic t_both();
    issue(1'b1, 1'b1, 8'h05, 8'h0b, 36'h3_c3c3_c3c3, 4'h0);
    wait_read(8'h05);
    shadow[8'h0b] = 36'h3_c3c3_c3c3;
    do_read(8'h0b);
    $display("test both ports done");
  endtask

  task automatic t_idle();
    logic seen;
    seen = 1'b0;
    repeat (16) step();
    repeat (40) begin
      step();
      if (rd_valid !== 1'b0 || u_ddr_sram_if.read_data_oe !== 1'b0) seen = 1'b1;
    end
    `CHECK("idle_quiet", 1'b0, seen)
    do_read(8'h06);
    $display("test idle done");
  endtask

  task automatic t_relock();
    logic off_seen;
    logic unlk_seen;
    int n;
    off_seen = 1'b0;
    unlk_seen = 1'b0;
    n = 0;
    step();
    relock_req = 1'b1;
    step();
    relock_req = 1'b0;
    while (n < 600 && !(off_seen && ready === 1'b1)) begin
      if (u_ddr_sram_if.dll_off_n === 1'b0) off_seen = 1'b1;
      if (dll_locked === 1'b0) unlk_seen = 1'b1;
      step();
      n++;
    end
    `CHECK("relock_off", 1'b1, off_seen)
    `CHECK("relock_unlocked", 1'b1, unlk_seen)
    do_read(8'h05);
    `CHECK("relocked", 1'b1, dll_locked)
    $display("test relock done");
  endtask

  task automatic t_half();
    do_write(8'h06, 36'h1_1111_2222, 4'b0001);
    do_write(8'h07, 36'h2_4680_1357, 4'h0);
    wait_idle();
    `CHECK("ecc_off", 1'b0, ecc_enabled)
    do_read(8'h06);
    $display("test half write done");
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    t_power();
    t_rw();
    t_mask();
    t_both();
    t_idle();
    t_relock();
    t_half();
    `CHECK("no_correction", 1'b0, corr_seen)
    conclude();
  end
endmodule
